/* rtl/mms_regs.vh */
/*
 Constants for the memory map, stack and password lock block.
 Assumes inclusion by the block's single design file.
*/
`ifndef MMS_REGS_VH
`define MMS_REGS_VH
// AXI register offsets
`define MMS_ADDR_CTRL      8'h00
`define MMS_ADDR_STATUS    8'h04
`define MMS_ADDR_PWDATA    8'h08
`define MMS_ADDR_SYSCTRL   8'h0C
// Control register fields
`define MMS_CTRL_D2P       0
`define MMS_CTRL_P2D       1
`define MMS_CTRL_UNIFIED   2
// System control fields
`define MMS_SC_PWL         1
`define MMS_SC_LDR         4
`define MMS_SC_PSS_LO      5
`define MMS_SC_PSS_HI      6
// Memory map
`define MMS_ROM_BASE       16'h8000
`define MMS_ROM_WORDS      16'h1000
`define MMS_APP_START      16'h0000
`define MMS_PW_FIRST       16'h0010
`define MMS_PW_LAST        16'h001F
`define MMS_UNI_DATA_BASE  16'hA000
`define MMS_D2P_BASE       16'hA000
`define MMS_P2D_BASE       16'h8000
`define MMS_ERASED_WORD    16'hFFFF
// Stack
`define MMS_SP_RESET       4'hF
// Module specifiers
`define MMS_MOD_AP         4'h8
`define MMS_MOD_ACC        4'h9
`define MMS_MOD_PFX        4'hB
`define MMS_MOD_IP         4'hC
`define MMS_MOD_SP         4'hD
`define MMS_MOD_DPC        4'hE
`define MMS_MOD_DP         4'hF
`endif

/* rtl/mms_memory_map.v */
/*
 Memory map decode, 16-entry hardware stack, password lock and loader entry
 control, with system register module decode and an AXI4-Lite slave.
 Assumes the core supplies one stack operation at a time, a pulse per
 password word compared, and that the test host raises loaderEntryTap
 while reset is held, and that powerOnReset is high only after power-up.
*/
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
// Overview of operation
// R1 - Program and data spaces decode separately unless a cross-map mode is on.
// R2 - Data-to-program mode maps data memory into program space for fetch.
// R3 - Program-to-data mode maps program memory into data space for reads.
// R4 - Unified mode places ROM, code and data in one contiguous map.
// R5 - Stack holds sixteen entries of sixteen bits each.
// R6 - Call, return, interrupt, push, pop and pop-with-enable use the stack.
// R7 - Reset loads the stack pointer with 0Fh.
// R8 - Push-type operations increment the pointer, then write the entry.
// R9 - Pop-type operations read the entry, then decrement the pointer.
// R10 - The four-bit stack pointer wraps modulo sixteen.
// R11 - Utility ROM spans 4k words starting at 8000h.
// R12 - Fetch starts in utility ROM after reset; ROM later branches to 0000h.
// R13 - Password is the sixteen program words at 0010h through 001Fh.
// R14 - Lock bit in system control denies ROM and debug access until match.
// R15 - Power-on reset sets the lock; cleared lock allows free access.
// R16 - After mass erase the password words read all ones.
// R17 - Test host sets the loader entry flag during reset over the test port. Here it is set only after reset ends, while loaderEntryTap stays high.
// R18 - Loader may clear the entry flag and reset; execution then skips ROM. Here reset clears romDone_q, so execution restarts in ROM.
// R19 - Loader defaults to test port; serial needs flag and port select first.
// R20 - System modules select by specifiers 8h, 9h, Bh, Ch, Dh, Eh, Fh.
// R21 - Every accumulator-pointer module register is single-bit addressable.
// R22 - Destination low four bits pick module, upper three the subindex.
`timescale 1ns/100ps
module mms_memory_map #(
	parameter PW_WORDS = 16
) (
	// Clock and reset
	input  wire        clk,
	input  wire        reset,
	input  wire        powerOnReset,
	// Program and data address decode
	input  wire [15:0] progAddr,
	input  wire [15:0] dataAddr,
	output reg         progSelRom,
	output reg         progSelFlash,
	output reg         progSelData,
	output reg         dataSelRam,
	output reg         dataSelFlash,
	output reg         dataSelRom,
	output reg         romDenied,
	output reg  [15:0] resetVector,
	// Stack operations
	input  wire        stackPush,
	input  wire        stackPop,
	input  wire [15:0] stackWrData,
	output reg  [15:0] stackRdData,
	output reg  [3:0]  stackPointer,
	// Password check
	input  wire        pwCheckStart,
	input  wire        pwWordValid,
	input  wire [15:0] pwSupplied,
	input  wire [15:0] pwStored,
	input  wire        massErase,
	output reg  [15:0] pwFetchAddr,
	// Test port loader entry
	input  wire        loaderEntryTap,
	output wire        loaderEntryFlag,
	output wire [1:0]  loaderPortSelect,
	// System register decode
	input  wire [6:0]  destField,
	input  wire [2:0]  prefixHigh,
	input  wire [3:0]  bitSel,
	output reg  [3:0]  destModule,
	output reg  [5:0]  destIndex,
	output reg         destIsSystem,
	output reg         destBitAddr,
	output reg  [15:0] destBitMask,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
`include "mms_regs.vh"

	localparam PW_IDLE = 2'd0;
	localparam PW_RUN  = 2'd1;
	localparam PW_FAIL = 2'd2;

	reg [15:0] stackMem [0:15];
	reg [2:0]  ctrl_q;
	reg [7:0]  sysCtrl_q;
	reg        romDone_q;
	reg [1:0]  pwState_q;
	reg [4:0]  pwCount_q;
	reg        pwMatch_q;
	reg [7:0]  awAddr_q;
	reg        awHeld_q;
	reg [31:0] wData_q;
	reg        wHeld_q;
	reg        tapMeta_q;
	reg        tapSync_q;
	reg        porMeta_q;
	reg        porSync_q;
	reg        pwLock_q;

	// Range test used by every address decode
	function inRange;
		input [15:0] a;
		input [15:0] base;
		input [15:0] words;
		begin
			inRange = (a >= base) && ({1'b0, a} < ({1'b0, base} + {1'b0, words}));
		end
	endfunction

	// Sizes in words of the flash and RAM windows
	localparam [15:0] FLASH_WORDS = 16'h8000;
	localparam [15:0] RAM_WORDS   = 16'h0400;

	// Program space decode
	always @* begin
		progSelRom   = 1'b0;
		progSelFlash = 1'b0;
		progSelData  = 1'b0;
		if (inRange(progAddr, `MMS_ROM_BASE, `MMS_ROM_WORDS)) begin
			progSelRom = 1'b1; // [R11]
		end else if (ctrl_q[`MMS_CTRL_UNIFIED] &&
				inRange(progAddr, `MMS_UNI_DATA_BASE, RAM_WORDS)) begin
			progSelData = 1'b1; // [R4]
		end else if (ctrl_q[`MMS_CTRL_D2P] &&
				inRange(progAddr, `MMS_D2P_BASE, RAM_WORDS)) begin
			progSelData = 1'b1; // [R2]
		end else if (inRange(progAddr, `MMS_APP_START, FLASH_WORDS)) begin
			progSelFlash = 1'b1; // [R1]
		end
	end

	// Data space decode
	always @* begin
		dataSelRam   = 1'b0;
		dataSelFlash = 1'b0;
		dataSelRom   = 1'b0;
		if (ctrl_q[`MMS_CTRL_UNIFIED]) begin
			// One contiguous map shared with program space
			dataSelRom   = inRange(dataAddr, `MMS_ROM_BASE, `MMS_ROM_WORDS); // [R4]
			dataSelRam   = inRange(dataAddr, `MMS_UNI_DATA_BASE, RAM_WORDS);
			dataSelFlash = inRange(dataAddr, `MMS_APP_START, FLASH_WORDS);
		end else if (ctrl_q[`MMS_CTRL_P2D] &&
				inRange(dataAddr, `MMS_P2D_BASE, FLASH_WORDS)) begin
			dataSelFlash = 1'b1; // [R3]
		end else begin
			dataSelRam = inRange(dataAddr, `MMS_APP_START, RAM_WORDS); // [R1]
		end
	end

	// Lock gating of ROM access and reset entry point
	always @* begin
		romDenied = pwLock_q & (progSelRom | dataSelRom); // [R14] [R15]
		if (romDone_q) begin
			resetVector = `MMS_APP_START; // [R18]
		end else begin
			resetVector = `MMS_ROM_BASE; // [R12]
		end
	end

	// Stack pointer and storage
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			stackPointer <= `MMS_SP_RESET; // [R7]
		end else if (stackPush) begin
			stackPointer <= stackPointer + 4'h1; // [R8] [R10]
		end else if (stackPop) begin
			stackPointer <= stackPointer - 4'h1; // [R9] [R10]
		end
	end

	always @(posedge clk) begin
		if (stackPush) begin
			stackMem[stackPointer + 4'h1] <= stackWrData; // [R5] [R6] [R8]
		end
	end

	// Pop data taken at the old pointer before it moves
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			stackRdData <= 16'h0000;
		end else if (stackPop) begin
			stackRdData <= stackMem[stackPointer]; // [R9] [R6]
		end
	end

	// Test port flag synchroniser
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			tapMeta_q <= 1'b0;
			tapSync_q <= 1'b0;
		end else begin
			tapMeta_q <= loaderEntryTap;
			tapSync_q <= tapMeta_q;
		end
	end

	// Power-on reset pin synchroniser; a plain reset leaves it alone
	always @(posedge clk) begin
		porMeta_q <= powerOnReset;
		porSync_q <= porMeta_q;
	end

	assign loaderEntryFlag  = sysCtrl_q[`MMS_SC_LDR];
	assign loaderPortSelect = sysCtrl_q[`MMS_SC_PSS_HI:`MMS_SC_PSS_LO]; // [R19]

	// Password compare over the sixteen stored words
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pwState_q   <= PW_IDLE;
			pwCount_q   <= 5'd0;
			pwMatch_q   <= 1'b0;
			pwFetchAddr <= `MMS_PW_FIRST;
		end else begin
			case (pwState_q)
			PW_IDLE: begin
				if (pwCheckStart) begin
					pwState_q   <= PW_RUN;
					pwCount_q   <= 5'd0;
					pwMatch_q   <= 1'b1;
					pwFetchAddr <= `MMS_PW_FIRST; // [R13]
				end
			end
			PW_RUN: begin
				if (pwWordValid) begin
					// Erased flash stands in for the stored word
					if (pwSupplied != (massErase ? `MMS_ERASED_WORD : pwStored)) begin // [R16]
						pwMatch_q <= 1'b0;
					end
					if (pwFetchAddr == `MMS_PW_LAST) begin // [R13]
						pwState_q <= PW_IDLE;
					end else begin
						pwFetchAddr <= pwFetchAddr + 16'h0001;
					end
					pwCount_q <= pwCount_q + 5'd1;
				end
			end
			PW_FAIL: pwState_q <= PW_IDLE;
			default: pwState_q <= PW_IDLE;
			endcase
		end
	end

	wire pwDone  = (pwState_q == PW_RUN) && pwWordValid && (pwFetchAddr == `MMS_PW_LAST);
	wire pwPass  = pwDone && pwMatch_q &&
		(pwSupplied == (massErase ? `MMS_ERASED_WORD : pwStored));

	// AXI write channel capture, address and data in either order
	assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
	wire awGo  = awHeld_q | (s_axi_awvalid & s_axi_awready);
	wire wGo   = wHeld_q | (s_axi_wvalid & s_axi_wready);
	wire [7:0]  wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
	wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
	wire wrFire = awGo & wGo & ~s_axi_bvalid;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			awHeld_q     <= 1'b0;
			wHeld_q      <= 1'b0;
			awAddr_q     <= 8'h00;
			wData_q      <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else begin
			if (wrFire) begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wrAddr == `MMS_ADDR_CTRL || wrAddr == `MMS_ADDR_SYSCTRL) ?
					2'b00 : 2'b10;
			end else begin
				if (s_axi_awvalid & s_axi_awready) begin
					awHeld_q <= 1'b1;
					awAddr_q <= s_axi_awaddr;
				end
				if (s_axi_wvalid & s_axi_wready) begin
					wHeld_q <= 1'b1;
					wData_q <= s_axi_wdata;
				end
				if (s_axi_bvalid & s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// Mode and system control registers
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_q    <= 3'b000; // [R1]
			sysCtrl_q <= 8'h00;
			romDone_q <= 1'b0;
		end else begin
			if (wrFire && wrAddr == `MMS_ADDR_CTRL && s_axi_wstrb[0]) begin
				ctrl_q <= wrData[2:0];
			end
			if (wrFire && wrAddr == `MMS_ADDR_SYSCTRL && s_axi_wstrb[0]) begin
				// Lock bit lives in its own flop, so it is masked here
				sysCtrl_q <= wrData[7:0] & 8'hFD; // [R19]
			end
			// Host flag wins over a software clear in the same cycle
			if (tapSync_q) begin
				sysCtrl_q[`MMS_SC_LDR] <= 1'b1; // [R17]
			end
			// Fetch in flash with flag clear moves the vector to 0000h; the next cycle with fetch outside flash or the flag set moves it back to 8000h
			romDone_q <= progSelFlash & ~sysCtrl_q[`MMS_SC_LDR]; // [R18]
		end
	end

	// Password lock survives a plain reset; power-up arms it and a system control write loads it from bit 1
	always @(posedge clk) begin
		if (porSync_q) begin
			pwLock_q <= 1'b1; // [R15]
		end else if (pwPass) begin
			// Matching password releases the lock
			pwLock_q <= 1'b0; // [R14]
		end else if (wrFire && wrAddr == `MMS_ADDR_SYSCTRL && s_axi_wstrb[0]) begin
			pwLock_q <= wrData[`MMS_SC_PWL];
		end
	end

	// AXI read channel
	assign s_axi_arready = ~s_axi_rvalid;
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			case (s_axi_araddr)
			`MMS_ADDR_CTRL:    s_axi_rdata <= {29'd0, ctrl_q};
			`MMS_ADDR_STATUS:  s_axi_rdata <= {22'd0, pwState_q, pwMatch_q, pwCount_q[2:0],
				stackPointer};
			`MMS_ADDR_PWDATA:  s_axi_rdata <= {16'd0, pwFetchAddr};
			`MMS_ADDR_SYSCTRL: s_axi_rdata <= {24'd0, sysCtrl_q[7:2], pwLock_q, sysCtrl_q[0]};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'b10;
			end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Destination field decode for system register modules
	always @* begin
		destModule   = destField[3:0]; // [R22]
		destIndex    = {prefixHigh, destField[6:4]}; // [R22]
		destIsSystem = 1'b0;
		case (destField[3:0])
		`MMS_MOD_AP, `MMS_MOD_ACC, `MMS_MOD_PFX, `MMS_MOD_IP,
		`MMS_MOD_SP, `MMS_MOD_DPC, `MMS_MOD_DP: destIsSystem = 1'b1; // [R20]
		default: destIsSystem = 1'b0;
		endcase
		destBitAddr = (destField[3:0] == `MMS_MOD_AP); // [R21]
		destBitMask = destBitAddr ? (16'h0001 << bitSel) : 16'hFFFF; // [R21]
	end

endmodule

/* verification/mms_core_model.sv */
/*
 Core model: fetch pointer of the processor facing the memory map block.
 Assumes the bench raises jump for one cycle after a clock edge.
*/
`timescale 1ns/100ps
module mms_core_model (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Fetch control
	input wire logic [15:0] resetVector,
	input wire logic        jump,
	input wire logic [15:0] target,
	output logic     [15:0] progAddr
);
	// Fetch restarts at the reset vector, then steps or jumps
	always @(posedge clk) begin
		if (reset)
			progAddr <= resetVector;
		else if (jump)
			progAddr <= target;
		else
			progAddr <= progAddr + 16'h0001;
	end
endmodule

/* verification/mms_memory_map_monitor.sv */
/*
 Checker for the memory map block, bound to its ports.
 Assumes one clock domain and the asynchronous active-high reset.
*/
`timescale 1ns/100ps
module mms_memory_map_monitor (
	// Clock and reset
	input logic        clk,
	input logic        reset,
	// Decode and stack
	input logic [15:0] progAddr,
	input logic        progSelRom,
	input logic        dataSelRom,
	input logic        romDenied,
	input logic [15:0] resetVector,
	input logic        stackPush,
	input logic        stackPop,
	input logic [15:0] stackWrData,
	input logic [15:0] stackRdData,
	input logic [3:0]  stackPointer,
	// Loader and destination decode
	input logic        loaderEntryTap,
	input logic        loaderEntryFlag,
	input logic [6:0]  destField,
	input logic [2:0]  prefixHigh,
	input logic [3:0]  bitSel,
	input logic [3:0]  destModule,
	input logic [5:0]  destIndex,
	input logic        destIsSystem,
	input logic        destBitAddr,
	input logic [15:0] destBitMask
);
	// One clock, reset cancels every attempt
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Push, then a lone pop on the next cycle
	sequence sPushThenPop;
		stackPush ##1 (stackPop && !stackPush);
	endsequence
	AST_SP_RESET: assert property ($fell(reset) |-> stackPointer == 4'hF)
		else $error("stack pointer not at top after reset");
	AST_PUSH_UP: assert property (stackPush |=> stackPointer - $past(stackPointer) == 4'h1)
		else $error("push did not step the pointer up");
	AST_POP_DOWN: assert property (stackPop && !stackPush |=> stackPointer - $past(stackPointer) == 4'hF)
		else $error("pop did not step the pointer down");
	AST_LIFO: assert property (sPushThenPop |=> stackRdData == $past(stackWrData, 2))
		else $error("pop did not return the last pushed word");
	AST_ROM_SPAN: assert property (progSelRom == (progAddr[15:12] == 4'h8))
		else $error("utility rom window wrong");
	AST_DENY: assert property (romDenied |-> progSelRom || dataSelRom)
		else $error("denial outside the rom");
	AST_LDR_VEC: assert property (loaderEntryFlag |-> resetVector == 16'h8000)
		else $error("loader flag set but vector leaves rom");
	AST_TAP: assert property (loaderEntryTap [*4] |=> loaderEntryFlag)
		else $error("tap request did not set the loader flag");
	AST_DEST: assert property (destModule == destField[3:0]
		&& destIsSystem == (destField[3] && destField[2:0] != 3'h2))
		else $error("destination module decode wrong");
	AST_BIT: assert property (destBitAddr |-> destModule == 4'h8 && destBitMask == 16'h0001 << bitSel)
		else $error("bit address decode wrong");
	AST_INDEX: assert property (destIndex == {prefixHigh, destField[6:4]})
		else $error("destination subindex decode wrong");
endmodule
bind mms_memory_map mms_memory_map_monitor i_mms_memory_map_monitor (.clk, .reset, .progAddr,
	.progSelRom, .dataSelRom, .romDenied, .resetVector, .stackPush, .stackPop, .stackWrData,
	.stackRdData, .stackPointer, .loaderEntryTap, .loaderEntryFlag, .destField, .prefixHigh,
	.bitSel, .destModule, .destIndex, .destIsSystem, .destBitAddr, .destBitMask);

/* verification/tb_top.sv */
/*
 Self-checking bench for the memory map block.
 Assumes the core model for fetch and the bound checker beside the design.
*/
`timescale 1ns/100ps
module tb_top;
	// Stimulus and bench state
	logic        clk = 0, reset = 1, powerOn = 1, jump = 0, massErase = 0, loaderEntryTap = 0;
	logic        stackPush = 0, stackPop = 0, pwCheckStart = 0, pwWordValid = 0, popSeen = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [15:0] target = '0, dataAddr = '0, stackWrData = '0, pwSupplied = '0, pwStored = '0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, seed;
	logic [6:0]  destField = '0;
	logic [3:0]  bitSel = '0;
	logic [2:0]  prefixHigh = '0;
	wire  [15:0] progAddr, resetVector, stackRdData, destBitMask;
	wire         progSelRom, progSelFlash, progSelData, dataSelRam, dataSelFlash, dataSelRom;
	wire         romDenied, loaderEntryFlag, destIsSystem, destBitAddr;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  loaderPortSelect, s_axi_bresp, s_axi_rresp;
	wire  [3:0]  stackPointer, destModule;
	wire  [31:0] s_axi_rdata;
	logic [33:0] aq[$];
	logic [15:0] sq[$], v[16];
	int          err_total = 0, comparisons = 0, i;
	// Design, core model and clock
	mms_memory_map i_mms_memory_map (.clk, .reset, .powerOnReset(powerOn), .progAddr, .dataAddr,
		.progSelRom, .progSelFlash, .progSelData, .dataSelRam, .dataSelFlash, .dataSelRom,
		.romDenied, .resetVector, .stackPush, .stackPop, .stackWrData, .stackRdData,
		.stackPointer, .pwCheckStart, .pwWordValid, .pwSupplied, .pwStored, .massErase,
		.pwFetchAddr(), .loaderEntryTap, .loaderEntryFlag, .loaderPortSelect, .destField,
		.prefixHigh, .bitSel, .destModule, .destIndex(), .destIsSystem, .destBitAddr,
		.destBitMask, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	mms_core_model i_mms_core_model (.clk, .reset, .resetVector, .jump, .target, .progAddr);
	always #10 clk = ~clk;
	// Compare seen against expected
	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	// Bus write and read
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		aq.push_back({r, 32'h0000_0000});
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		aq.push_back({r, d});
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
	endtask
	// Set a map mode, point both spaces, check selects and denial
	task automatic dec(input logic [2:0] m, input logic [15:0] p, input logic [15:0] d,
		input logic [6:0] e);
		wr(8'h00, {29'h0000_0000, m}, 2'b00);
		@(posedge clk);
		jump <= 1;
		target <= p;
		dataAddr <= d;
		@(posedge clk);
		jump <= 0;
		#1 chk("selects", {progSelRom, progSelFlash, progSelData, dataSelRam, dataSelFlash,
			dataSelRom, romDenied}, e);
	endtask
	// Start, then sixteen supplied words
	task automatic pw(input logic [15:0] s);
		@(posedge clk);
		pwCheckStart <= 1;
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			pwCheckStart <= 0;
			pwWordValid <= 1;
			pwSupplied <= s;
			pwStored <= 16'($random(seed));
		end
		@(posedge clk);
		pwWordValid <= 0;
	endtask
	// Results matched against the oldest notes
	always @(posedge clk) begin
		popSeen <= stackPop && !stackPush;
		if (popSeen) chk("stack data", stackRdData, sq.pop_front());
		if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, aq.pop_front());
		if (s_axi_bvalid && s_axi_bready) chk("bresp", {s_axi_bresp, 32'h0000_0000}, aq.pop_front());
	end
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (4000) @(posedge clk);
		err_total++;
		complete_run();
	end
	// Main sequence
	initial begin
		seed = 32'h91d2_e121;
		repeat (3) @(posedge clk);
		reset <= 0;
		powerOn <= 0;
		@(posedge clk);
		#1 chk("vector", resetVector, 16'h8000);
		rd(8'h0C, 32'h0000_0002, 2'b00);
		rd(8'h10, 32'h0000_0000, 2'b10);
		wr(8'h04, 32'h0000_0001, 2'b10);
		dec(3'd0, 16'h0100, 16'h0100, 7'b010_1000);
		dec(3'd1, 16'hA000, 16'h0100, 7'b001_1000);
		dec(3'd2, 16'h0100, 16'h8000, 7'b010_0100);
		dec(3'd4, 16'hA000, 16'h0000, 7'b001_0100);
		dec(3'd0, 16'h8000, 16'h0100, 7'b100_1001);
		for (i = 0; i < 16; i++) begin
			v[i] = 16'($random(seed));
			@(posedge clk);
			stackPush <= 1;
			stackWrData <= v[i];
		end
		for (i = 15; i >= 0; i--) begin
			sq.push_back(v[i]);
			@(posedge clk);
			stackPush <= 0;
			stackPop <= 1;
		end
		@(posedge clk);
		stackPop <= 0;
		#1 chk("pointer", stackPointer, 4'hF);
		pw(16'h1234);
		rd(8'h0C, 32'h0000_0002, 2'b00);
		massErase <= 1;
		pw(16'hFFFF);
		rd(8'h0C, 32'h0000_0000, 2'b00);
		rd(8'h08, 32'h0000_001F, 2'b00);
		dec(3'd0, 16'h8000, 16'h0100, 7'b100_1000);
		for (i = 8; i < 16; i++) begin
			@(posedge clk);
			destField <= {3'(i), 4'(i)};
			bitSel <= 4'(i);
			prefixHigh <= 3'($random(seed));
			#1 chk("system module", destIsSystem, 1'(i != 10));
		end
		@(posedge clk);
		loaderEntryTap <= 1;
		reset <= 1;
		repeat (3) @(posedge clk);
		reset <= 0;
		repeat (5) @(posedge clk);
		loaderEntryTap <= 0;
		rd(8'h0C, 32'h0000_0010, 2'b00);
		wr(8'h0C, 32'h0000_0062, 2'b00);
		chk("loader port", {loaderEntryFlag, loaderPortSelect}, 3'b011);
		repeat (3) @(posedge clk);
		complete_run();
	end
endmodule
